// ---- lcims_pkg.sv ----
// constants for the line channel interrupt mask and status block
package lcims_pkg;

  localparam int unsigned LCIMS_ADR_W = 8;
  localparam int unsigned LCIMS_DAT_W = 32;
  localparam int unsigned LCIMS_REG_W = 8;
  localparam int unsigned LCIMS_LVL_N = 11;

  // word offsets of the register file
  localparam logic [7:0] LCIMS_OFF_MASK0 = 8'h00;
  localparam logic [7:0] LCIMS_OFF_MASK1 = 8'h04;
  localparam logic [7:0] LCIMS_OFF_MASK2 = 8'h08;
  localparam logic [7:0] LCIMS_OFF_CONDITION_STATUS_0 = 8'h0C;
  localparam logic [7:0] LCIMS_OFF_STAT1 = 8'h10;
  localparam logic [7:0] LCIMS_OFF_INTS0 = 8'h14;
  localparam logic [7:0] LCIMS_OFF_INTS1 = 8'h18;
  localparam logic [7:0] LCIMS_OFF_INTS2 = 8'h1C;
  localparam logic [7:0] LCIMS_OFF_EDGE  = 8'h20;

  // implemented bits; every other position reads zero
  localparam logic [7:0] LCIMS_IMPL0 = 8'hFF;
  localparam logic [7:0] LCIMS_IMPL1 = 8'hE3;
  localparam logic [7:0] LCIMS_IMPL2 = 8'h3F;
  localparam logic [7:0] LCIMS_CONDITION_STATUS_0_IMPL = 8'h9F;
  localparam logic [7:0] LCIMS_EDGE_IMPL  = 8'h7F;

  // reset values: masks block everything, status and flags clear
  localparam logic [7:0] LCIMS_MASK_RST = 8'hFF;
  localparam logic [7:0] LCIMS_ZERO_RST = 8'h00;

  // status 0 and interrupt status 0 bit positions
  localparam int unsigned LCIMS_B_AUTOLP = 7;
  localparam int unsigned LCIMS_B_AMP    = 7;
  localparam int unsigned LCIMS_B_TJA    = 6;
  localparam int unsigned LCIMS_B_RJA    = 5;
  localparam int unsigned LCIMS_B_TOC    = 4;
  localparam int unsigned LCIMS_B_TCK    = 3;
  localparam int unsigned LCIMS_B_TLOS   = 2;
  localparam int unsigned LCIMS_B_SLOS   = 1;
  localparam int unsigned LCIMS_B_LLOS   = 0;

  // status 1 and interrupt status 1 bit positions
  localparam int unsigned LCIMS_B_SAIS = 7;
  localparam int unsigned LCIMS_B_LAIS = 6;
  localparam int unsigned LCIMS_B_PA   = 5;
  localparam int unsigned LCIMS_B_IBA  = 1;
  localparam int unsigned LCIMS_B_IBD  = 0;

  // edge select bit positions
  localparam int unsigned LCIMS_E_AIS = 6;
  localparam int unsigned LCIMS_E_PA  = 5;
  localparam int unsigned LCIMS_E_TOC = 4;
  localparam int unsigned LCIMS_E_TCK = 3;
  localparam int unsigned LCIMS_E_TLOS = 2;
  localparam int unsigned LCIMS_E_LOS = 1;
  localparam int unsigned LCIMS_E_IB  = 0;

endpackage

// ---- lcims_tb.sv ----
// self-checking bench for the channel mask and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lcims_pkg::*;

  localparam int SRC_N = 19;

  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        loop_r   = 1'b0;
  logic        ce_r     = 1'b1;
  // bit 8*r+b drives the source gated by mask register r, bit b
  logic [23:0] src      = 24'h0;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          src_reg [SRC_N] = '{0,0,0,0,0,0,0,0,1,1,1,1,1,2,2,2,2,2,2};
  int          src_bit [SRC_N] = '{7,6,5,4,3,2,1,0,7,6,5,1,0,5,4,3,2,1,0};

  lcims_top u_lcims_top (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .ce_i                       (ce_r),
    .wb_cyc_i                   (wb_cyc_i),
    .wb_stb_i                   (wb_stb_i),
    .wb_we_i                    (wb_we_i),
    .wb_adr_i                   (wb_adr_i),
    .wb_sel_i                   (wb_sel_i),
    .wb_dat_i                   (wb_dat_i),
    .wb_dat_o                   (wb_dat_o),
    .wb_ack_o                   (wb_ack_o),
    .irq_o                      (irq_o),
    .auto_loopback_i            (loop_r),
    .driver_overcurrent_i       (src[4]),
    .tx_clock_missing_i         (src[3]),
    .tx_signal_loss_i           (src[2]),
    .system_signal_loss_i       (src[1]),
    .line_signal_loss_i         (src[0]),
    .system_alarm_ind_i         (src[15]),
    .line_alarm_ind_i           (src[14]),
    .pattern_sync_i             (src[13]),
    .inband_activate_i          (src[9]),
    .inband_deactivate_i        (src[8]),
    .amplitude_overflow_i       (src[7]),
    .tx_jitter_fifo_i           (src[6]),
    .rx_jitter_fifo_i           (src[5]),
    .system_bipolar_violation_i (src[21]),
    .line_bipolar_violation_i   (src[20]),
    .system_excess_zeros_i      (src[19]),
    .line_excess_zeros_i        (src[18]),
    .pattern_bit_error_i        (src[17]),
    .error_counter_overflow_i   (src[16])
  );

  always #5 clk_i = ~clk_i;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp,
                           input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_irq(input logic exp, input string msg);
    total_checks++;
    if (irq_o !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s irq %b", $time, msg, irq_o);
    end
  endtask

  // classic cycle: hold the request until ack is seen high at an edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [7:0] d, input logic sel0,
                         output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= {4{sel0}};
    wb_dat_i <= {24'h0, d};
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, adr, d, 1'b1, q);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp,
                        input string msg);
    logic [7:0] q;
    wb_xfer(1'b0, adr, 8'h00, 1'b1, q);
    check_reg(q, exp, msg);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // event sources are one-cycle pulses, the rest are held levels
  task automatic drive_src(input int idx, input logic v);
    @(posedge clk_i);
    src[idx] <= v;
    if (v && (idx >= 16 || (idx >= 5 && idx < 8))) begin
      @(posedge clk_i);
      src[idx] <= 1'b0;
    end
  endtask

  initial begin
    int r;
    int b;
    int i;
    logic [7:0] q;
    logic [7:0] m_adr;
    logic [7:0] f_adr;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(LCIMS_OFF_MASK0, 8'hFF, "mask0 reset");
    rd_chk(LCIMS_OFF_MASK1, 8'hE3, "mask1 reset");
    rd_chk(LCIMS_OFF_MASK2, 8'h3F, "mask2 reset");
    rd_chk(LCIMS_OFF_CONDITION_STATUS_0, 8'h00, "status reset");
    rd_chk(8'h24, 8'h00, "unmapped read");
    wr(LCIMS_OFF_MASK1, 8'h00);
    rd_chk(LCIMS_OFF_MASK1, 8'h00, "mask1 cleared");
    wr(LCIMS_OFF_MASK1, 8'hFF);
    rd_chk(LCIMS_OFF_MASK1, 8'hE3, "mask1 reserved");
    wb_xfer(1'b1, LCIMS_OFF_MASK0, 8'h00, 1'b0, q);
    rd_chk(LCIMS_OFF_MASK0, 8'hFF, "write without select");
    wr(LCIMS_OFF_CONDITION_STATUS_0, 8'hFF);
    rd_chk(LCIMS_OFF_CONDITION_STATUS_0, 8'h00, "status read only");
    $display("test reset and access done");
    for (i = 0; i < 6; i++) begin
      b = (i == 5) ? 7 : i;
      @(posedge clk_i);
      if (b == 7) loop_r <= 1'b1;
      else src[b] <= 1'b1;
      wait_cyc(4);
      rd_chk(LCIMS_OFF_CONDITION_STATUS_0, 8'(1 << b), "status high");
      @(posedge clk_i);
      if (b == 7) loop_r <= 1'b0;
      else src[b] <= 1'b0;
      wait_cyc(4);
      rd_chk(LCIMS_OFF_CONDITION_STATUS_0, 8'h00, "status low");
    end
    check_irq(1'b0, "all sources blocked");
    wr(LCIMS_OFF_INTS0, 8'hFF);
    $display("test live status done");
    for (i = 0; i < SRC_N; i++) begin
      r = src_reg[i];
      b = src_bit[i];
      m_adr = 8'(LCIMS_OFF_MASK0 + 4 * r);
      f_adr = 8'(LCIMS_OFF_INTS0 + 4 * r);
      wr(m_adr, ~8'(1 << b));
      drive_src(8 * r + b, 1'b1);
      wait_cyc(8);
      check_irq(1'b1, "unmasked source");
      rd_chk(f_adr, 8'(1 << b), "flag set");
      wr(f_adr, 8'(1 << b));
      wait_cyc(2);
      check_irq(1'b0, "flag cleared");
      // clear before the fall so a falling edge would show
      drive_src(8 * r + b, 1'b0);
      wait_cyc(8);
      rd_chk(f_adr, 8'h00, "no flag on fall");
      wr(m_adr, 8'hFF);
      drive_src(8 * r + b, 1'b1);
      wait_cyc(8);
      check_irq(1'b0, "masked source");
      drive_src(8 * r + b, 1'b0);
      wait_cyc(8);
      wr(f_adr, 8'hFF);
    end
    $display("test mask gating done");
    wr(LCIMS_OFF_EDGE, 8'hFF);
    rd_chk(LCIMS_OFF_EDGE, 8'h7F, "edge select reserved");
    wr(LCIMS_OFF_EDGE, 8'h10);
    wr(LCIMS_OFF_MASK0, 8'hEF);
    drive_src(4, 1'b1);
    wait_cyc(8);
    wr(LCIMS_OFF_INTS0, 8'h10);
    wait_cyc(2);
    check_irq(1'b0, "edge flag cleared");
    drive_src(4, 1'b0);
    wait_cyc(8);
    check_irq(1'b1, "falling edge raises");
    rd_chk(LCIMS_OFF_INTS0, 8'h10, "falling edge flag");
    wr(LCIMS_OFF_INTS0, 8'hFF);
    wr(LCIMS_OFF_MASK0, 8'hFF);
    wr(LCIMS_OFF_EDGE, 8'h00);
    $display("test edge select done");
    // a pulse while the clock enable is low is not seen
    @(posedge clk_i);
    ce_r <= 1'b0;
    drive_src(7, 1'b1);
    @(posedge clk_i);
    ce_r <= 1'b1;
    rd_chk(LCIMS_OFF_INTS0, 8'h00, "pulse while frozen");
    // event lands in the very cycle that the clear is taken
    drive_src(7, 1'b1);
    fork
      wr(LCIMS_OFF_INTS0, 8'h80);
      begin
        wait_cyc(2);
        src[7] <= 1'b1;
        @(posedge clk_i);
        src[7] <= 1'b0;
      end
    join
    rd_chk(LCIMS_OFF_INTS0, 8'h80, "event wins over clear");
    wr(LCIMS_OFF_INTS0, 8'hFF);
    $display("test freeze and clear race done");
    finish_test();
  end

  // the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end

endmodule
`default_nettype wire

// ---- lcims_top.sv ----
// per-channel interrupt masks, condition status and interrupt flags
// Function
// - mask bits are 0 to enable, 1 to block; all reset to 1
// - mask 0 bit 7 gates the transmit amplitude overflow interrupt
// - mask 0 bit 6 gates the transmit jitter FIFO interrupt
// - mask 0 bit 5 gates the receive jitter FIFO interrupt
// - mask 0 bit 4 gates the driver over-current interrupt
// - mask 0 bit 3 gates the transmit clock missing interrupt
// - mask 0 bits 2..0 gate transmit, system, line signal loss
// - mask 1 bit 7 gates the system alarm indication interrupt
// - mask 1 bit 6 gates the line alarm indication interrupt
// - mask 1 bit 5 gates the test pattern sync change interrupt
// - mask 2 bits 5 and 4 gate system and line bipolar violations
// - mask 2 bits 3 and 2 gate system and line excess zeros
// - mask 2 bit 1 gates the pattern bit error interrupt
// - mask 2 bit 0 gates the error counter overflow interrupt
// - status 0 bit 7 shows automatic loopback; zero after reset
// - status 0 bit 4 shows live driver over-current; zero after reset
// - status 0 bit 3 shows transmit clock missing; zero after reset
// - status 0 bit 2 shows transmit signal loss; zero after reset
// - status 0 bits 1, 0 show system and line loss; zero after reset
// - unmasked set flags drive the interrupt pin; writing 1 clears
// - status flags set on rising edge, or either edge when edge select is 1; event flags set while the input is high
`timescale 1ns/1ps
`default_nettype none
module lcims_top
  import lcims_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [LCIMS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [LCIMS_DAT_W-1:0] wb_dat_i,
  output logic      [LCIMS_DAT_W-1:0] wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        irq_o,
  input  wire logic                   auto_loopback_i,
  input  wire logic                   driver_overcurrent_i,
  input  wire logic                   tx_clock_missing_i,
  input  wire logic                   tx_signal_loss_i,
  input  wire logic                   system_signal_loss_i,
  input  wire logic                   line_signal_loss_i,
  input  wire logic                   system_alarm_ind_i,
  input  wire logic                   line_alarm_ind_i,
  input  wire logic                   pattern_sync_i,
  input  wire logic                   inband_activate_i,
  input  wire logic                   inband_deactivate_i,
  input  wire logic                   amplitude_overflow_i,
  input  wire logic                   tx_jitter_fifo_i,
  input  wire logic                   rx_jitter_fifo_i,
  input  wire logic                   system_bipolar_violation_i,
  input  wire logic                   line_bipolar_violation_i,
  input  wire logic                   system_excess_zeros_i,
  input  wire logic                   line_excess_zeros_i,
  input  wire logic                   pattern_bit_error_i,
  input  wire logic                   error_counter_overflow_i
);

  function automatic logic [7:0] impl_of(input logic [1:0] idx);
    unique case (idx)
      2'd0:    impl_of = LCIMS_IMPL0;
      2'd1:    impl_of = LCIMS_IMPL1;
      default: impl_of = LCIMS_IMPL2;
    endcase
  endfunction

  function automatic logic edge_hit(input logic prev,
                                    input logic cur,
                                    input logic both);
    edge_hit = both ? (prev ^ cur) : (~prev & cur);
  endfunction

  logic [LCIMS_LVL_N-1:0] lvl_raw;
  logic [LCIMS_LVL_N-1:0] lvl_s1;
  logic [LCIMS_LVL_N-1:0] lvl_s2;
  logic [7:0]             mask [3];
  logic [7:0]             flag [3];
  logic [7:0]             set_v [3];
  logic [7:0]             clr_v [3];
  logic [7:0]             edge_sel;
  logic [7:0]             condition_status_0;
  logic [7:0]             stat1;
  logic [7:0]             prev0;
  logic [7:0]             prev1;
  logic [7:0]             both0;
  logic [7:0]             both1;
  logic [7:0]             hit0;
  logic [7:0]             hit1;
  logic [7:0]             rd_byte;
  logic                   req;
  logic                   wr_go;
  logic                   next_irq;

  assign lvl_raw = {auto_loopback_i, driver_overcurrent_i,
                    tx_clock_missing_i, tx_signal_loss_i,
                    system_signal_loss_i, line_signal_loss_i,
                    system_alarm_ind_i, line_alarm_ind_i,
                    pattern_sync_i, inband_activate_i,
                    inband_deactivate_i};

  // detector levels come from other clock regions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_s1 <= '0;
      lvl_s2 <= '0;
    end else if (ce_i) begin
      lvl_s1 <= lvl_raw;
      lvl_s2 <= lvl_s1;
    end
  end

  assign condition_status_0 = {lvl_s2[10], 2'b00, lvl_s2[9:5]};
  assign stat1 = {lvl_s2[4:2], 3'b000, lvl_s2[1:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev0 <= LCIMS_ZERO_RST;
      prev1 <= LCIMS_ZERO_RST;
    end else if (ce_i) begin
      prev0 <= condition_status_0;
      prev1 <= stat1;
    end
  end

  // one edge-select bit may cover a pair of flags
  always_comb begin
    both0 = '0;
    both1 = '0;
    both0[LCIMS_B_TOC]  = edge_sel[LCIMS_E_TOC];
    both0[LCIMS_B_TCK]  = edge_sel[LCIMS_E_TCK];
    both0[LCIMS_B_TLOS] = edge_sel[LCIMS_E_TLOS];
    both0[LCIMS_B_SLOS] = edge_sel[LCIMS_E_LOS];
    both0[LCIMS_B_LLOS] = edge_sel[LCIMS_E_LOS];
    both1[LCIMS_B_SAIS] = edge_sel[LCIMS_E_AIS];
    both1[LCIMS_B_LAIS] = edge_sel[LCIMS_E_AIS];
    both1[LCIMS_B_PA]   = edge_sel[LCIMS_E_PA];
    both1[LCIMS_B_IBA]  = edge_sel[LCIMS_E_IB];
    both1[LCIMS_B_IBD]  = edge_sel[LCIMS_E_IB];
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_edge
      assign hit0[g] = edge_hit(prev0[g], condition_status_0[g], both0[g]);
      assign hit1[g] = edge_hit(prev1[g], stat1[g], both1[g]);
    end
  endgenerate

  // loopback has no flag, so bit 7 of flag 0 is amplitude overflow
  always_comb begin
    set_v[0] = {amplitude_overflow_i, tx_jitter_fifo_i,
                rx_jitter_fifo_i, hit0[4:0]};
    set_v[1] = hit1 & LCIMS_IMPL1;
    set_v[2] = {2'b00, system_bipolar_violation_i,
                line_bipolar_violation_i, system_excess_zeros_i,
                line_excess_zeros_i, pattern_bit_error_i,
                error_counter_overflow_i};
  end

  // register bus: answer one cycle after the request, write on ack
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & wb_ack_o & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_comb begin
    unique case (wb_adr_i)
      LCIMS_OFF_MASK0: rd_byte = mask[0];
      LCIMS_OFF_MASK1: rd_byte = mask[1];
      LCIMS_OFF_MASK2: rd_byte = mask[2];
      LCIMS_OFF_CONDITION_STATUS_0: rd_byte = condition_status_0;
      LCIMS_OFF_STAT1: rd_byte = stat1;
      LCIMS_OFF_INTS0: rd_byte = flag[0];
      LCIMS_OFF_INTS1: rd_byte = flag[1];
      LCIMS_OFF_INTS2: rd_byte = flag[2];
      LCIMS_OFF_EDGE:  rd_byte = edge_sel;
      default:         rd_byte = LCIMS_ZERO_RST;
    endcase
  end

  // read data is latched at the request edge and held with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && req && !wb_ack_o) begin
      wb_dat_o <= {{(LCIMS_DAT_W-LCIMS_REG_W){1'b0}}, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        mask[i] <= LCIMS_MASK_RST & impl_of(2'(i));
      end
    end else if (ce_i && wr_go) begin
      if (wb_adr_i == LCIMS_OFF_MASK0) begin
        mask[0] <= wb_dat_i[7:0] & LCIMS_IMPL0;
      end
      if (wb_adr_i == LCIMS_OFF_MASK1) begin
        mask[1] <= wb_dat_i[7:0] & LCIMS_IMPL1;
      end
      if (wb_adr_i == LCIMS_OFF_MASK2) begin
        mask[2] <= wb_dat_i[7:0] & LCIMS_IMPL2;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_sel <= LCIMS_ZERO_RST;
    end else if (ce_i && wr_go && wb_adr_i == LCIMS_OFF_EDGE) begin
      edge_sel <= wb_dat_i[7:0] & LCIMS_EDGE_IMPL;
    end
  end

  always_comb begin
    clr_v[0] = '0;
    clr_v[1] = '0;
    clr_v[2] = '0;
    if (wr_go) begin
      if (wb_adr_i == LCIMS_OFF_INTS0) clr_v[0] = wb_dat_i[7:0];
      if (wb_adr_i == LCIMS_OFF_INTS1) clr_v[1] = wb_dat_i[7:0];
      if (wb_adr_i == LCIMS_OFF_INTS2) clr_v[2] = wb_dat_i[7:0];
    end
  end

  // write one clears
  // a new event in the clearing cycle wins, so none is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        flag[i] <= LCIMS_ZERO_RST;
      end
    end else if (ce_i) begin
      for (int i = 0; i < 3; i++) begin
        flag[i] <= ((flag[i] & ~clr_v[i]) | set_v[i]) & impl_of(2'(i));
      end
    end
  end

  assign next_irq = |(flag[0] & ~mask[0]) | |(flag[1] & ~mask[1])
                  | |(flag[2] & ~mask[2]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= next_irq;
    end
  end

  // checks -----------------------------------------------------------

  sequence wr_ints0_s;
    ce_i && wr_go && wb_adr_i == LCIMS_OFF_INTS0;
  endsequence

  sequence toc_rise_s;
    ce_i && !condition_status_0[LCIMS_B_TOC] ##1 ce_i && condition_status_0[LCIMS_B_TOC];
  endsequence

  sequence toc_fall_s;
    ce_i && condition_status_0[LCIMS_B_TOC] ##1 ce_i && !condition_status_0[LCIMS_B_TOC];
  endsequence

  mask_reset_a: assert property (
    @(posedge clk_i) $fell(rst_i) |-> mask[0] == LCIMS_IMPL0
      && mask[1] == LCIMS_IMPL1 && mask[2] == LCIMS_IMPL2)
    else $error("mask registers not all set after reset");

  gate0_irq_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && |(flag[0] & ~mask[0]) |=> irq_o)
    else $error("unmasked flag 0 did not raise the interrupt");

  gate1_irq_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && |(flag[1] & ~mask[1]) |=> irq_o)
    else $error("unmasked flag 1 did not raise the interrupt");

  gate2_irq_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && |(flag[2] & ~mask[2]) |=> irq_o)
    else $error("unmasked flag 2 did not raise the interrupt");

  masked_quiet_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !next_irq && flag[0] != 8'h00 |=> !irq_o)
    else $error("masked flag raised the interrupt");

  stat_live_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && $past(ce_i) && $past(ce_i, 2)
      && !$past(rst_i) && !$past(rst_i, 2) |->
      condition_status_0 == ({$past(auto_loopback_i, 2), 2'b00,
                 $past(driver_overcurrent_i, 2),
                 $past(tx_clock_missing_i, 2),
                 $past(tx_signal_loss_i, 2),
                 $past(system_signal_loss_i, 2),
                 $past(line_signal_loss_i, 2)} & LCIMS_CONDITION_STATUS_0_IMPL))
    else $error("status 0 does not follow its detectors");

  stat_reset_a: assert property (
    @(posedge clk_i) $fell(rst_i) |-> condition_status_0 == LCIMS_ZERO_RST)
    else $error("status 0 not clear after reset");

  rise_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    toc_rise_s |=> flag[0][LCIMS_B_TOC])
    else $error("rising condition did not set its flag");

  fall_edge_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    toc_fall_s ##0 (edge_sel[LCIMS_E_TOC] && !flag[0][LCIMS_B_TOC]
      && !wr_go) |=> flag[0][LCIMS_B_TOC] == edge_sel[LCIMS_E_TOC])
    else $error("falling condition handled against edge select");

  w1c_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_ints0_s ##0 (wb_dat_i[LCIMS_B_AMP] && !amplitude_overflow_i)
      |=> !flag[0][LCIMS_B_AMP])
    else $error("write of one did not clear the flag");

  set_wins_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_ints0_s ##0 amplitude_overflow_i |=> flag[0][LCIMS_B_AMP])
    else $error("event lost in the clearing cycle");

  reserved_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mask[1] & ~LCIMS_IMPL1) == 8'h00 && (mask[2] & ~LCIMS_IMPL2) == 8'h00
      && (edge_sel & ~LCIMS_EDGE_IMPL) == 8'h00)
    else $error("reserved bit became set");

  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge lasted more than one cycle");

  read_upper_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[LCIMS_DAT_W-1:LCIMS_REG_W] == '0)
    else $error("read data above the register byte not zero");

endmodule
`default_nettype wire
